/* common/tpps_cfg.svh */
// Constants for the shared test-pin ownership block.
// Assumes a 100 MHz system clock; the test clock is sampled, not used as a clock.
`ifndef TPPS_CFG_SVH
`define TPPS_CFG_SVH
`define TPPS_ADDR_CTRL      12'h000
`define TPPS_ADDR_STATUS    12'h004
`define TPPS_ADDR_PROBE_A   12'h008
`define TPPS_ADDR_PROBE_B   12'h00C
`define TPPS_ADDR_QCLK      12'h010
`define TPPS_ADDR_NODES     12'h014
`define TPPS_CTRL_RST       32'h0000_0000
`define TPPS_QCLK_RST       32'h0000_0000
`define TPPS_NODE_W         32
`define TPPS_SEL_W          5
`define TPPS_NQUAD          4
`define TPPS_RESET_TCKS     3'h5
`define TPPS_CTRL_DEDIC     0
`define TPPS_CTRL_PR_EN     1
`define TPPS_CTRL_PR_KILL   2
`define TPPS_CTRL_CSUM_GO   3
`define TPPS_CTRL_TRST_EN   4
`define TPPS_CSUM_LEN       8'h20
`define TPPS_STAT_TAP_HI    3
`define TPPS_STAT_ACT       4
`define TPPS_STAT_BUSY      5
`define TPPS_STAT_CBIT      6
`define TPPS_SY_IDLE        2'h3
`endif

/* common/tpps_pkg.sv */
// Types for the shared test-pin ownership block.
// Assumes tpps_cfg.svh is on the include path.
package tpps_pkg;
  // Test state machine states, standard 16-state encoding
  typedef enum logic [3:0] {
    TPPS_TLR = 4'hF, TPPS_RTI = 4'hC, TPPS_SDS = 4'h7, TPPS_CDR = 4'h6,
    TPPS_SDR = 4'h2, TPPS_E1D = 4'h1, TPPS_PDR = 4'h3, TPPS_E2D = 4'h0,
    TPPS_UDR = 4'h5, TPPS_SIS = 4'h4, TPPS_CIR = 4'hE, TPPS_SIR = 4'hA,
    TPPS_E1I = 4'h9, TPPS_PIR = 4'hB, TPPS_E2I = 4'h8, TPPS_UIR = 4'hD
  } tpps_tap_t;
endpackage

/* design/tpps_tap.sv */
// Test access state machine advanced on sampled test clock rising edges.
// Assumes tck_rise is a one-cycle enable from the main clock domain.
`timescale 1ns/1ns
`default_nettype none
module tpps_tap
  import tpps_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             arst_n,
  input  wire logic             trst_n_s,
  input  wire logic             tck_rise,
  input  wire logic             tms_s,
  output tpps_pkg::tpps_tap_t   state
);
  typedef struct packed {
    tpps_tap_t st;
  } tpps_tap_st_t;
  tpps_tap_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (!trst_n_s) begin
      s_d.st = TPPS_TLR;
    end else if (tck_rise) begin
      case (s_q.st)
        TPPS_TLR: s_d.st = tms_s ? TPPS_TLR : TPPS_RTI;
        TPPS_RTI: s_d.st = tms_s ? TPPS_SDS : TPPS_RTI;
        TPPS_SDS: s_d.st = tms_s ? TPPS_SIS : TPPS_CDR;
        TPPS_CDR: s_d.st = tms_s ? TPPS_E1D : TPPS_SDR;
        TPPS_SDR: s_d.st = tms_s ? TPPS_E1D : TPPS_SDR;
        TPPS_E1D: s_d.st = tms_s ? TPPS_UDR : TPPS_PDR;
        TPPS_PDR: s_d.st = tms_s ? TPPS_E2D : TPPS_PDR;
        TPPS_E2D: s_d.st = tms_s ? TPPS_UDR : TPPS_SDR;
        TPPS_UDR: s_d.st = tms_s ? TPPS_SDS : TPPS_RTI;
        TPPS_SIS: s_d.st = tms_s ? TPPS_TLR : TPPS_CIR;
        TPPS_CIR: s_d.st = tms_s ? TPPS_E1I : TPPS_SIR;
        TPPS_SIR: s_d.st = tms_s ? TPPS_E1I : TPPS_SIR;
        TPPS_E1I: s_d.st = tms_s ? TPPS_UIR : TPPS_PIR;
        TPPS_PIR: s_d.st = tms_s ? TPPS_E2I : TPPS_PIR;
        TPPS_E2I: s_d.st = tms_s ? TPPS_UIR : TPPS_SIR;
        TPPS_UIR: s_d.st = tms_s ? TPPS_SDS : TPPS_RTI;
        default:  s_d.st = TPPS_TLR;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{st: TPPS_TLR};
    end else begin
      s_q <= s_d;
    end
  end

  assign state = s_q.st;
endmodule // tpps_tap
`default_nettype wire

/* design/tpps_top.sv */
// Ownership of the shared test pins, probe outputs and quadrant clock pins.
// Assumes an APB master on mclk; test pins arrive asynchronously and are synchronised here.
// Summary of operation
// - Flexible mode: test mode select low hands clock, data pins to scan.
// - Pins stay in test duty until the state machine reaches logic reset.
// - Five test clocks with mode select high reach logic reset.
// - Dedicated mode follows standard scan protocol, no pin sharing.
// - Checksum run drives test data out; pin returns to scan (in test duty) or user afterwards.
// - Two probe pins each show any selected internal node live.
// - Probes may become user I/O, and can be disabled permanently.
// - Four quadrant clock pins drive quadrants or act as plain I/O.
// - Active-low test reset, synchronised to mclk, initialises scan circuit when enabled.
`include "tpps_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tpps_top
  import tpps_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      arst_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      tms_pin,
  input  wire logic                      tck_pin,
  input  wire logic                      tdi_pin,
  input  wire logic                      trst_n_pin,
  output logic                           tdo_out,
  output logic                           tdo_oe,
  input  wire logic                      user_tdo_out,
  input  wire logic                      user_tdo_oe,
  output logic                           user_tck_in,
  output logic                           user_tdi_in,
  output logic                           test_active,
  input  wire logic [`TPPS_NODE_W-1:0]   node_bus,
  input  wire logic                      user_pra_out,
  input  wire logic                      user_prb_out,
  output logic                           probe_out_a,
  output logic                           probe_out_b,
  input  wire logic [`TPPS_NQUAD-1:0]    quadrant_clock_inputs,
  output logic [`TPPS_NQUAD-1:0]         quad_clk_en,
  output logic [`TPPS_NQUAD-1:0]         quad_user_in
);
  typedef struct packed {
    logic [1:0]              tms_sy;
    logic [1:0]              tck_sy;
    logic [1:0]              tdi_sy;
    logic [1:0]              trst_sy;
    logic                    tck_prev;
    logic                    act;
    logic                    dedic;
    logic                    pr_en;
    logic                    pr_kill;
    logic                    trst_en;
    logic [`TPPS_SEL_W-1:0]  sel_a;
    logic [`TPPS_SEL_W-1:0]  sel_b;
    logic [`TPPS_NQUAD-1:0]  qclk_use;
    logic [`TPPS_NQUAD-1:0]  qgrp;
    logic                    csum_busy;
    logic [7:0]              csum_cnt;
    logic                    csum_bit;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    tdo_out;
    logic                    tdo_oe;
    logic                    tck_in;
    logic                    tdi_in;
    logic                    pa;
    logic                    pb;
    logic [`TPPS_NQUAD-1:0]  qen;
    logic [`TPPS_NQUAD-1:0]  qin;
  } tpps_st_t;
  tpps_st_t s_q, s_d;

  tpps_tap_t tap_state;
  logic      tck_rise;
  logic      trst_eff_n;
  logic [`TPPS_NQUAD-1:0] q_sy1_q, q_sy2_q;

  // Test clock idles low and tck_prev resets low, so no false edge follows reset
  assign tck_rise   = s_q.tck_sy[1] & ~s_q.tck_prev;
  // reset only honoured when the pin is reserved as test reset
  assign trst_eff_n = ~s_q.trst_en | s_q.trst_sy[1];

  tpps_tap u_tap (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .trst_n_s (trst_eff_n),
    .tck_rise (tck_rise),
    .tms_s    (s_q.tms_sy[1]),
    .state    (tap_state)
  );

  // Quadrant pins synchronised separately; they are plain inputs when not clocks
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q_sy1_q <= '0;
      q_sy2_q <= '0;
    end else begin
      q_sy1_q <= quadrant_clock_inputs;
      q_sy2_q <= q_sy1_q;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.tms_sy  = {s_q.tms_sy[0], tms_pin};
    s_d.tck_sy  = {s_q.tck_sy[0], tck_pin};
    s_d.tdi_sy  = {s_q.tdi_sy[0], tdi_pin};
    s_d.trst_sy = {s_q.trst_sy[0], trst_n_pin};
    s_d.tck_prev = s_q.tck_sy[1];
    // dedicated mode keeps pins in test duty permanently
    if (s_q.dedic) begin
      s_d.act = 1'b1;
    // flexible mode, select low claims the pins
    end else if (!s_q.tms_sy[1]) begin
      s_d.act = 1'b1;
    // released once logic reset is reached
    // A low mode select above wins, so the pins never flicker free
    end else if (tap_state == TPPS_TLR) begin
      s_d.act = 1'b0;
    end
    // checksum run owns test data out for a fixed length
    // Counts test clock rises, so a host that stops the clock stalls the run
    if (s_q.csum_busy) begin
      if (tck_rise) begin
        s_d.csum_bit = s_q.csum_bit ^ s_q.tdi_sy[1];
        if (s_q.csum_cnt == 8'h01) begin
          s_d.csum_busy = 1'b0;
        end
        s_d.csum_cnt = s_q.csum_cnt - 8'h01;
      end
    end
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    // Setup cycle decodes and registers the answer, so pready and read
    // data come straight from flops in the access cycle that follows
    if (psel && !penable) begin
      s_d.pready = 1'b1;
      s_d.prdata = '0;
      case (paddr)
        `TPPS_ADDR_CTRL: begin
          s_d.prdata[`TPPS_CTRL_DEDIC]   = s_q.dedic;
          s_d.prdata[`TPPS_CTRL_PR_EN]   = s_q.pr_en;
          s_d.prdata[`TPPS_CTRL_PR_KILL] = s_q.pr_kill;
          s_d.prdata[`TPPS_CTRL_CSUM_GO] = s_q.csum_busy;
          s_d.prdata[`TPPS_CTRL_TRST_EN] = s_q.trst_en;
        end
        `TPPS_ADDR_STATUS: begin
          s_d.prdata[`TPPS_STAT_TAP_HI:0] = tap_state;
          s_d.prdata[`TPPS_STAT_ACT]      = s_q.act;
          s_d.prdata[`TPPS_STAT_BUSY]     = s_q.csum_busy;
          s_d.prdata[`TPPS_STAT_CBIT]     = s_q.csum_bit;
        end
        `TPPS_ADDR_PROBE_A: begin
          s_d.prdata[`TPPS_SEL_W-1:0] = s_q.sel_a;
        end
        `TPPS_ADDR_PROBE_B: begin
          s_d.prdata[`TPPS_SEL_W-1:0] = s_q.sel_b;
        end
        `TPPS_ADDR_QCLK: begin
          s_d.prdata[2*`TPPS_NQUAD-1:0] = {s_q.qgrp, s_q.qclk_use};
        end
        `TPPS_ADDR_NODES: begin
          s_d.prdata = node_bus;
        end
        // Unmapped: error response, read data stays zero
        default: begin
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    // Access edge with pready high is the only edge at which a write lands;
    // the master may still change its request until then
    if (psel && penable && s_q.pready && pwrite) begin
      case (paddr)
        `TPPS_ADDR_CTRL: begin
          s_d.dedic   = pwdata[`TPPS_CTRL_DEDIC];
          s_d.pr_en   = pwdata[`TPPS_CTRL_PR_EN] & ~s_q.pr_kill;
          s_d.trst_en = pwdata[`TPPS_CTRL_TRST_EN];
          // kill is one-way until power-up reset
          if (pwdata[`TPPS_CTRL_PR_KILL]) begin
            s_d.pr_kill = 1'b1;
            s_d.pr_en   = 1'b0;
          end
          // a new run starts only when none is in flight
          if (pwdata[`TPPS_CTRL_CSUM_GO] && !s_q.csum_busy) begin
            s_d.csum_busy = 1'b1;
            s_d.csum_cnt  = `TPPS_CSUM_LEN;
            s_d.csum_bit  = 1'b0;
          end
        end
        `TPPS_ADDR_PROBE_A: begin
          s_d.sel_a = pwdata[`TPPS_SEL_W-1:0];
        end
        `TPPS_ADDR_PROBE_B: begin
          s_d.sel_b = pwdata[`TPPS_SEL_W-1:0];
        end
        `TPPS_ADDR_QCLK: begin
          s_d.qclk_use = pwdata[`TPPS_NQUAD-1:0];
          s_d.qgrp     = pwdata[2*`TPPS_NQUAD-1:`TPPS_NQUAD];
        end
        // Unmapped writes are dropped; the error went out in the setup answer
        default: begin
        end
      endcase
    end
    // pins follow the registered flag, not the raw mode select
    s_d.tck_in = s_q.act ? 1'b0 : s_q.tck_sy[1];
    s_d.tdi_in = s_q.act ? 1'b0 : s_q.tdi_sy[1];
    // Checksum outranks scan so a run started mid-test still drives the pin
    if (s_q.csum_busy) begin
      s_d.tdo_out = s_q.csum_bit;
      s_d.tdo_oe  = 1'b1;
    end else if (s_q.act) begin
      s_d.tdo_out = s_q.tdi_sy[1];
      s_d.tdo_oe  = (tap_state == TPPS_SDR) || (tap_state == TPPS_SIR);
    end else begin
      s_d.tdo_out = user_tdo_out;
      s_d.tdo_oe  = user_tdo_oe;
    end
    // probe shows live node or falls back to user logic
    if (s_q.pr_en) begin
      s_d.pa = node_bus[s_q.sel_a];
      s_d.pb = node_bus[s_q.sel_b];
    end else begin
      s_d.pa = user_pra_out;
      s_d.pb = user_prb_out;
    end
    // quadrant pin either gates clock to its quadrants or is I/O
    s_d.qen = s_q.qclk_use | (s_q.qgrp & {`TPPS_NQUAD{|s_q.qclk_use}});
    s_d.qin = q_sy2_q & ~s_q.qclk_use;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q         <= '0;
      // Synchronisers start at the pins' idle levels, so leaving reset
      // does not look like mode select or test reset driven low
      s_q.tms_sy  <= `TPPS_SY_IDLE;
      s_q.trst_sy <= `TPPS_SY_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata       = s_q.prdata;
  // Fixed single access cycle, no wait states
  assign pready       = s_q.pready;
  assign pslverr      = s_q.pslverr;
  assign tdo_out      = s_q.tdo_out;
  assign tdo_oe       = s_q.tdo_oe;
  assign user_tck_in  = s_q.tck_in;
  assign user_tdi_in  = s_q.tdi_in;
  assign test_active  = s_q.act;
  assign probe_out_a  = s_q.pa;
  assign probe_out_b  = s_q.pb;
  assign quad_clk_en  = s_q.qen;
  assign quad_user_in = s_q.qin;
endmodule // tpps_top
`default_nettype wire

/* tb/tpps_top_sva.sv */
// Checker for the shared test-pin ownership block, bound to tpps_top.
// Assumes the bench raises mode select whenever test reset is pulsed.
`include "tpps_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tpps_top_sva (
  input wire logic                   mclk,
  input wire logic                   arst_n,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   tms_pin,
  input wire logic                   trst_n_pin,
  input wire logic                   test_active,
  input wire logic                   user_tck_in,
  input wire logic                   user_tdi_in,
  input wire logic [`TPPS_NQUAD-1:0] quad_clk_en,
  input wire logic [`TPPS_NQUAD-1:0] quad_user_in
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  ready_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
  error_access_a: assert property (pslverr |-> pready) else $error("pslverr outside access");
  setup_answer_a: assert property (psel && !penable |=> pready ##1 !pready) else $error("access not one cycle");
  pin_owner_a: assert property (test_active && $past(test_active) |-> !user_tck_in && !user_tdi_in)
    else $error("user sees pins in test duty");
  flex_enter_a: assert property ($fell(tms_pin) |-> ##[1:5] test_active) else $error("no test duty");
  hold_test_a: assert property (test_active && !tms_pin && trst_n_pin |=> test_active) else $error("early release");
  release_cause_a: assert property ($fell(test_active) |-> $past(tms_pin, 4) || !$past(trst_n_pin, 4))
    else $error("release without cause");
  quad_excl_a: assert property ((quad_clk_en & quad_user_in) == 4'h0) else $error("quad pin both uses");
endmodule // tpps_top_sva
`default_nettype wire

/* tb/tpps_host.sv */
// Scan host model: drives mode select, data in, test clock and test reset.
// Test clock stands still low between frames; 160 ns per bit.
`timescale 1ns/1ns
`default_nettype none
module tpps_host (
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  output var logic trst_n
);
  initial begin
    tck = 0;
    tms = 1;
    tdi = 1;
    trst_n = 1;
  end
  // mode select per bit
  // Called on an mclk rising edge; pins move 3 or 8 ns off the 10 ns grid so
  // none changes on a sampling edge, and each call ends on an edge again
  task automatic shift(input logic m, input logic d);
    #3 tms = m;
    tdi = d;
    #75 tck = 1;
    #80 tck = 0;
    #2;
  endtask
  task automatic reset_pulse();
    #3 tms = 1;
    trst_n = 0;
    #200 trst_n = 1;
    #7;
  endtask
endmodule // tpps_host
`default_nettype wire

/* tb/tpps_top_test.sv */
// Self-checking bench for tpps_top with an APB master and a scan host.
// Assumes tpps_cfg.svh on the include path.
`include "tpps_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tpps_top_test;
  import tpps_pkg::*;
  logic        mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        user_tdo_out = 0, user_tdo_oe = 0, user_pra_out = 0, user_prb_out = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, node_bus = 32'h0, prdata, rdv, nb;
  logic [3:0]  quadrant_clock_inputs = 4'hF, quad_clk_en, quad_user_in;
  logic        pready, pslverr, erv, tdo_out, tdo_oe, user_tck_in, user_tdi_in, test_active;
  logic        probe_out_a, probe_out_b, tck_pin, tms_pin, tdi_pin, trst_n_pin, ua, ub;
  int          n_mismatch = 0, checked = 0, cyc = 0, sa, sb, q, qi;
  tpps_host tpps_host_i (.tck(tck_pin), .tms(tms_pin), .tdi(tdi_pin), .trst_n(trst_n_pin));
  tpps_top tpps_top_i (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tms_pin, .tck_pin, .tdi_pin, .trst_n_pin, .tdo_out, .tdo_oe, .user_tdo_out, .user_tdo_oe, .user_tck_in,
    .user_tdi_in, .test_active, .node_bus, .user_pra_out, .user_prb_out, .probe_out_a, .probe_out_b,
    .quadrant_clock_inputs, .quad_clk_en, .quad_user_in);
  always #5 mclk = ~mclk;
  task automatic end_of_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk) if (++cyc == 20000) begin
    n_mismatch++;
    end_of_test();
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1, a, d); endtask
  task automatic rd(input logic [11:0] a); apb(0, a, 0); endtask
  task automatic w(input int n); repeat (n) @(posedge mclk); endtask
  initial begin
    sa = $urandom(47);
    w(20);
    arst_n <= 1;
    rd(`TPPS_ADDR_CTRL);
    chk("ctrl reset", rdv, `TPPS_CTRL_RST);
    rd(`TPPS_ADDR_QCLK);
    chk("qclk reset", rdv, `TPPS_QCLK_RST);
    rd(12'h018);
    chk("unmapped err", erv, 1);
    chk("unmapped data", rdv, 0);
    // Walk into shift-data so release needs all five bits
    host_i_walk();
    w(8);
    chk("active", test_active, 1);
    chk("tdi gated", user_tdi_in, 0);
    repeat (4) tpps_host_i.shift(1, 1);
    w(8);
    chk("held", test_active, 1);
    tpps_host_i.shift(1, 1);
    w(8);
    chk("released", test_active, 0);
    chk("tdi user", user_tdi_in, 1);
    rd(`TPPS_ADDR_STATUS);
    chk("tap reset", rdv[3:0], TPPS_TLR);
    wr(`TPPS_ADDR_CTRL, 32'h1 << `TPPS_CTRL_DEDIC);
    w(8);
    chk("dedicated", test_active, 1);
    wr(`TPPS_ADDR_CTRL, 32'h1 << `TPPS_CTRL_TRST_EN);
    w(8);
    chk("dedicated off", test_active, 0);
    tpps_host_i.shift(0, 1);
    w(8);
    chk("pre reset", test_active, 1);
    tpps_host_i.reset_pulse();
    w(8);
    chk("test reset", test_active, 0);
    sa = $urandom_range(31);
    sb = $urandom_range(31);
    nb = $urandom;
    ua = ~nb[sa];
    ub = ~nb[sb];
    node_bus <= nb;
    user_pra_out <= ua;
    user_prb_out <= ub;
    wr(`TPPS_ADDR_PROBE_A, sa);
    wr(`TPPS_ADDR_PROBE_B, sb);
    wr(`TPPS_ADDR_CTRL, 32'h1 << `TPPS_CTRL_PR_EN);
    w(4);
    chk("probe a", probe_out_a, nb[sa]);
    chk("probe b", probe_out_b, nb[sb]);
    rd(`TPPS_ADDR_NODES);
    chk("nodes", rdv, nb);
    wr(`TPPS_ADDR_CTRL, 32'h1 << `TPPS_CTRL_PR_KILL);
    wr(`TPPS_ADDR_CTRL, 32'h1 << `TPPS_CTRL_PR_EN);
    w(4);
    chk("killed a", probe_out_a, ua);
    chk("killed b", probe_out_b, ub);
    q = $urandom_range(15);
    qi = $urandom_range(15);
    quadrant_clock_inputs <= qi[3:0];
    wr(`TPPS_ADDR_QCLK, q);
    w(6);
    chk("quad clock", quad_clk_en, q);
    chk("quad user", quad_user_in, qi & ~q & 15);
    wr(`TPPS_ADDR_CTRL, 32'h1 << `TPPS_CTRL_CSUM_GO);
    w(4);
    chk("csum drive", tdo_oe, 1);
    repeat (`TPPS_CSUM_LEN) tpps_host_i.shift(1, 1);
    user_tdo_out <= 1;
    w(8);
    chk("csum done oe", tdo_oe, 0);
    chk("user tdo", tdo_out, 1);
    rd(`TPPS_ADDR_STATUS);
    chk("csum idle", rdv[`TPPS_STAT_BUSY], 0);
    end_of_test();
  end
  task automatic host_i_walk();
    tpps_host_i.shift(0, 1);
    tpps_host_i.shift(1, 1);
    repeat (2) tpps_host_i.shift(0, 1);
  endtask
endmodule // tpps_top_test
bind tpps_top tpps_top_sva tpps_top_sva_i (.mclk, .arst_n, .psel, .penable, .pready, .pslverr, .tms_pin,
  .trst_n_pin, .test_active, .user_tck_in, .user_tdi_in, .quad_clk_en, .quad_user_in);
`default_nettype wire
